// *** core/tsr_status_readout.sv ***
// Functional notes
// - host clocks mode enable, status bits shift out
// - readout allowed: io flag clear, high supply
// - readout allowed: core flag clear, low supply
// - after idle timeout clear released sticky bits S4..S12
// - output low when presented bit set
// - S0 mirrors local wake flag live
// - S1 mirrors remote wake flag live
// - S2 mirrors node configuration flag live
// - S3 latches power on seen
// - S4 latches bus error until cleared
// - S5 latches temperature high flag
// - S6 latches temperature medium flag
// - S7 latches tx gate stuck flag
// - S8..S10 latch supply undervoltage flags
// - S11 latches hub lockout entry
// - S12 latches star branch collision
// - summary error while any S4..S12 set
module tsr_status_readout
  import tsr_pkg::*;
#(
  parameter int IDLE_CYCLES = tsr_pkg::IDLE_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // read clock from host
  input wire logic mode_enable_pin,
  // status output, open drain
  output logic status_serial_out_n,
  output logic statusOutEnable,
  // supply qualification
  input wire logic ioSupplyHigh,
  input wire logic ioSupplyLowRange,
  input wire logic io_supply_low_flag,
  input wire logic core_supply_low_flag,
  // live flags
  input wire logic localWakeFlag,
  input wire logic remoteWakeFlag,
  input wire logic endpoint_config,
  // flags feeding sticky bits
  input wire logic power_on_seen,
  input wire logic busErrorFlag,
  input wire logic tempHighFlag,
  input wire logic tempMediumFlag,
  input wire logic tx_gate_stuck,
  input wire logic battery_low_status,
  input wire logic coreUndervoltFlag,
  input wire logic ioUndervoltFlag,
  input wire logic hub_lockout_entered,
  input wire logic branchCollision,
  // status views
  output logic [tsr_pkg::STATUS_WIDTH-1:0] serial_status_word,
  output logic summaryError
);
  import tsr_pkg::*;

  // ----------------------------------------
  // input synchronisation
  // ----------------------------------------
  localparam int NUM_IN = 18;
  // slot of each input in the synchroniser
  localparam int IN_POWER_ON = 0;
  localparam int IN_BUS_ERROR = 1;
  localparam int IN_TEMP_HIGH = 2;
  localparam int IN_TEMP_MEDIUM = 3;
  localparam int IN_TX_GATE = 4;
  localparam int IN_BATTERY_LOW = 5;
  localparam int IN_CORE_UNDERVOLT = 6;
  localparam int IN_IO_UNDERVOLT = 7;
  localparam int IN_HUB_LOCKOUT = 8;
  localparam int IN_COLLISION = 9;
  localparam int IN_NODE_CONFIG = 10;
  localparam int IN_REMOTE_WAKE = 11;
  localparam int IN_LOCAL_WAKE = 12;
  localparam int IN_CORE_LOW = 13;
  localparam int IN_IO_LOW = 14;
  localparam int IN_SUP_LOW = 15;
  localparam int IN_SUP_HIGH = 16;
  localparam int IN_READ_CLK = 17;
  logic [NUM_IN-1:0] rawIn;
  logic [NUM_IN-1:0] syncIn;

  // every input crosses into the clock domain
  assign rawIn[IN_POWER_ON] = power_on_seen;
  assign rawIn[IN_BUS_ERROR] = busErrorFlag;
  assign rawIn[IN_TEMP_HIGH] = tempHighFlag;
  assign rawIn[IN_TEMP_MEDIUM] = tempMediumFlag;
  assign rawIn[IN_TX_GATE] = tx_gate_stuck;
  assign rawIn[IN_BATTERY_LOW] = battery_low_status;
  assign rawIn[IN_CORE_UNDERVOLT] = coreUndervoltFlag;
  assign rawIn[IN_IO_UNDERVOLT] = ioUndervoltFlag;
  assign rawIn[IN_HUB_LOCKOUT] = hub_lockout_entered;
  assign rawIn[IN_COLLISION] = branchCollision;
  assign rawIn[IN_NODE_CONFIG] = endpoint_config;
  assign rawIn[IN_REMOTE_WAKE] = remoteWakeFlag;
  assign rawIn[IN_LOCAL_WAKE] = localWakeFlag;
  assign rawIn[IN_CORE_LOW] = core_supply_low_flag;
  assign rawIn[IN_IO_LOW] = io_supply_low_flag;
  assign rawIn[IN_SUP_LOW] = ioSupplyLowRange;
  assign rawIn[IN_SUP_HIGH] = ioSupplyHigh;
  assign rawIn[IN_READ_CLK] = mode_enable_pin;

  // three stages, change taken once the last two agree
  tsr_sync #(
    .WIDTH(NUM_IN)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .asyncIn(rawIn),
    .settled(syncIn)
  );

  logic readClk;
  logic supHigh;
  logic supLow;
  logic ioLowFlag;
  logic coreLowFlag;
  logic [2:0] liveFlags;
  logic [STICKY_COUNT-1:0] stickySrc;

  assign readClk = syncIn[IN_READ_CLK];
  assign supHigh = syncIn[IN_SUP_HIGH];
  assign supLow = syncIn[IN_SUP_LOW];
  assign ioLowFlag = syncIn[IN_IO_LOW];
  assign coreLowFlag = syncIn[IN_CORE_LOW];
  assign liveFlags[0] = syncIn[IN_LOCAL_WAKE];
  assign liveFlags[1] = syncIn[IN_REMOTE_WAKE];
  assign liveFlags[2] = syncIn[IN_NODE_CONFIG];
  // sticky sources in status bit order, S3 first
  assign stickySrc[0] = syncIn[IN_POWER_ON];
  assign stickySrc[1] = syncIn[IN_BUS_ERROR];
  assign stickySrc[2] = syncIn[IN_TEMP_HIGH];
  assign stickySrc[3] = syncIn[IN_TEMP_MEDIUM];
  assign stickySrc[4] = syncIn[IN_TX_GATE];
  assign stickySrc[5] = syncIn[IN_BATTERY_LOW];
  assign stickySrc[6] = syncIn[IN_CORE_UNDERVOLT];
  assign stickySrc[7] = syncIn[IN_IO_UNDERVOLT];
  assign stickySrc[8] = syncIn[IN_HUB_LOCKOUT];
  assign stickySrc[9] = syncIn[IN_COLLISION];

  // ----------------------------------------
  // access qualification and edge finding
  // ----------------------------------------
  logic accessOk;
  logic readClkPrev;
  logic readEdge;

  // either supply window opens the register
  assign accessOk = (!ioLowFlag && supHigh) || (!coreLowFlag && supLow);

  // starts at the idle level of the pin, so no false edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readClkPrev <= 1'b0;
    end else begin
      readClkPrev <= readClk;
    end
  end

  // ----------------------------------------
  // read clock edges
  // ----------------------------------------
  // any edge of the read clock counts, only while access is allowed
  assign readEdge = (readClk != readClkPrev) && accessOk;

  // ----------------------------------------
  // readout sequencing
  // ----------------------------------------
  tsr_state_t state;
  tsr_state_t next_state;
  logic idleExpired;
  logic clearPulse;

  // a read starts on the first accepted edge
  always_comb begin
    next_state = state;
    case (state)
      TSR_IDLE: begin
        if (readEdge) begin
          next_state = TSR_READING;
        end
      end
      TSR_READING: begin
        if (!readEdge && idleExpired) begin
          next_state = TSR_WAIT_CLEAR;
        end
      end
      TSR_WAIT_CLEAR: begin
        next_state = TSR_IDLE;
      end
      default: begin
        next_state = TSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= TSR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // clear fires once when the idle time has run out after a read
  assign clearPulse = (state == TSR_WAIT_CLEAR);

  // ----------------------------------------
  // idle timer
  // ----------------------------------------
  logic [31:0] idleCount;
  logic [31:0] next_idleCount;

  assign idleExpired = (idleCount >= IDLE_CYCLES[31:0]);

  // restarts on every accepted edge, holds once expired
  always_comb begin
    next_idleCount = idleCount;
    if (readEdge || state != TSR_READING) begin
      next_idleCount = 32'h00000000;
    end else if (!idleExpired) begin
      next_idleCount = idleCount + 32'h00000001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idleCount <= 32'h00000000;
    end else begin
      idleCount <= next_idleCount;
    end
  end

  // ----------------------------------------
  // bit pointer
  // ----------------------------------------
  logic [PTR_WIDTH-1:0] bitPtr;
  logic [PTR_WIDTH-1:0] next_bitPtr;

  // S0 shown while idle; each accepted edge moves on one bit, S12 holds
  always_comb begin
    next_bitPtr = bitPtr;
    if (state == TSR_WAIT_CLEAR) begin
      next_bitPtr = PTR_FIRST;
    end else if (readEdge) begin
      if (bitPtr != PTR_LAST) begin
        next_bitPtr = bitPtr + 4'h1;
      end
    end else if (state == TSR_IDLE) begin
      next_bitPtr = PTR_FIRST;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bitPtr <= PTR_FIRST;
    end else begin
      bitPtr <= next_bitPtr;
    end
  end

  // ----------------------------------------
  // status word
  // ----------------------------------------
  logic [STICKY_COUNT-1:0] sticky;
  logic [STICKY_COUNT-1:0] clearable;

  // set wins over clear; clear only where the flag has gone away
  // S3 only falls at reset, S4 to S12 on the post-read clear
  generate
    for (genvar i = 0; i < STICKY_COUNT; i++) begin : g_sticky
      assign clearable[i] = ((STICKY_FIRST + i) >= STICKY_LOW);
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sticky[i] <= STATUS_RESET[STICKY_FIRST+i];
        end else if (stickySrc[i]) begin
          sticky[i] <= 1'b1;
        end else if (clearPulse && clearable[i]) begin
          sticky[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // assembled status word
  // ----------------------------------------
  logic [STATUS_WIDTH-1:0] next_word;

  always_comb begin
    next_word = STATUS_RESET;
    next_word[BIT_LOCAL_WAKE] = liveFlags[0];
    next_word[BIT_REMOTE_WAKE] = liveFlags[1];
    next_word[BIT_NODE_CONFIG] = liveFlags[2];
    next_word[STICKY_HIGH:STICKY_FIRST] = sticky;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_status_word <= STATUS_RESET;
    end else begin
      serial_status_word <= next_word;
    end
  end

  // ----------------------------------------
  // summary error
  // ----------------------------------------
  // high while any clearable status bit is set
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      summaryError <= 1'b0;
    end else begin
      summaryError <= |next_word[STICKY_HIGH:STICKY_LOW];
    end
  end

  // ----------------------------------------
  // serial output
  // ----------------------------------------
  logic presentedBit;

  // bit chosen by the pointer
  assign presentedBit = next_word[bitPtr];

  // data level, low while the presented bit is set
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_serial_out_n <= 1'b1;
    end else begin
      status_serial_out_n <= ~presentedBit;
    end
  end

  // pull only while the register may be read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      statusOutEnable <= 1'b0;
    end else begin
      statusOutEnable <= presentedBit && accessOk;
    end
  end
endmodule // tsr_status_readout

// *** core/tsr_pkg.sv ***
package tsr_pkg;
  // status word layout
  localparam int STATUS_WIDTH = 13;
  localparam int BIT_LOCAL_WAKE = 0;
  localparam int BIT_REMOTE_WAKE = 1;
  localparam int BIT_NODE_CONFIG = 2;
  localparam int BIT_POWER_ON = 3;
  localparam int STICKY_LOW = 4;
  localparam int STICKY_HIGH = 12;
  localparam int STICKY_FIRST = 3;
  localparam int STICKY_COUNT = 10;
  localparam logic [STATUS_WIDTH-1:0] STATUS_RESET = 13'h0000;
  // clock and timing
  localparam int CLK_HZ = 50000000;
  localparam int IDLE_TIMEOUT_US = 20;
  localparam int IDLE_TIMEOUT_CYCLES = (CLK_HZ / 1000000) * IDLE_TIMEOUT_US;
  localparam int PTR_WIDTH = 4;
  localparam logic [PTR_WIDTH-1:0] PTR_LAST = 4'hC;
  localparam logic [PTR_WIDTH-1:0] PTR_FIRST = 4'h0;
  typedef enum logic [1:0] {TSR_IDLE, TSR_READING, TSR_WAIT_CLEAR} tsr_state_t;
endpackage : tsr_pkg

// *** core/tsr_sync.sv ***
module tsr_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // asynchronous input and settled output
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] settled
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // change accepted once the last two stages agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settled <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          settled[i] <= stage3[i];
        end
      end
    end
  end
endmodule // tsr_sync

// *** tb/tsr_sva.sv ***
module tsr_sva
  import tsr_pkg::*;
#(
  parameter int IDLE_CYCLES = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins and access
  input wire logic mode_enable_pin,
  input wire logic status_serial_out_n,
  input wire logic statusOutEnable,
  input wire logic ioSupplyHigh,
  input wire logic ioSupplyLowRange,
  input wire logic io_supply_low_flag,
  input wire logic core_supply_low_flag,
  // flags and views
  input wire logic localWakeFlag,
  input wire logic endpoint_config,
  input wire logic busErrorFlag,
  input wire logic [tsr_pkg::STATUS_WIDTH-1:0] serial_status_word,
  input wire logic summaryError
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire accessOk = (!io_supply_low_flag && ioSupplyHigh) || (!core_supply_low_flag && ioSupplyLowRange);
  int idleCount;
  logic pinLast;
  // cycles since the read clock last moved
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idleCount <= 0;
      pinLast <= 1'b0;
    end else begin
      pinLast <= mode_enable_pin;
      idleCount <= (pinLast != mode_enable_pin) ? 0 : idleCount + 1;
    end
  end
  a_out_polarity: assert property (statusOutEnable |-> !status_serial_out_n)
    else $error("line pulled while data high");
  a_summary_set: assert property (|serial_status_word[12:4] |-> ##[0:2] summaryError)
    else $error("summary missing");
  a_summary_clear: assert property (!(|serial_status_word[12:4]) |-> ##[0:2] !summaryError)
    else $error("summary stuck");
  a_local_live: assert property ($stable(localWakeFlag) [*8] |-> serial_status_word[0] == localWakeFlag)
    else $error("local wake bit stale");
  a_node_live: assert property ($stable(endpoint_config) [*8] |-> serial_status_word[2] == endpoint_config)
    else $error("node bit stale");
  a_power_kept: assert property (!$fell(serial_status_word[3]))
    else $error("power bit cleared");
  a_bus_latch: assert property (busErrorFlag [*8] |-> serial_status_word[4])
    else $error("bus error not latched");
  a_clear_released: assert property ($fell(serial_status_word[4]) |-> !$past(busErrorFlag, 5) && !$past(busErrorFlag, 6))
    else $error("cleared while flag set");
  a_clear_idle: assert property ($fell(serial_status_word[4]) |-> idleCount >= IDLE_CYCLES)
    else $error("cleared before idle timeout");
  a_no_access: assert property (!accessOk [*6] |-> !statusOutEnable)
    else $error("line driven without access");
endmodule // tsr_sva

bind tsr_status_readout tsr_sva #(.IDLE_CYCLES(IDLE_CYCLES)) chk_i (.clk, .reset_n, .mode_enable_pin,
  .status_serial_out_n, .statusOutEnable, .ioSupplyHigh, .ioSupplyLowRange, .io_supply_low_flag,
  .core_supply_low_flag, .localWakeFlag, .endpoint_config, .busErrorFlag, .serial_status_word, .summaryError);

// *** tb/tsr_host_model.sv ***
module tsr_host_model (
  // clock
  input wire logic clk,
  // line and read clock
  input wire logic statusOutEnable,
  output logic mode_enable_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // 160 ns read clock: four 20 ns cycles per half period
  localparam int HALF_CYCLES = 4;
  // a bit shows about six cycles after its edge, so it is taken inside the next half period
  localparam int SAMPLE_CYCLES = 3;
  // pull-up on the open-drain line
  wire lineLevel = statusOutEnable ? 1'b0 : 1'b1;
  initial mode_enable_pin = 1'b0;
  task automatic read_word(output logic [12:0] word);
    word = '0;
    @(negedge clk);
    word[0] = (lineLevel === 1'b0);
    for (int i = 1; i < 14; i++) begin
      if (i < 13) begin
        mode_enable_pin = !mode_enable_pin;
      end
      repeat (SAMPLE_CYCLES) @(negedge clk);
      if (i > 1) begin
        word[i-1] = (lineLevel === 1'b0);
      end
      repeat (HALF_CYCLES - SAMPLE_CYCLES) @(negedge clk);
    end
  endtask
endmodule // tsr_host_model

// *** tb/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ioSupplyHigh = 1'b1;
  logic ioSupplyLowRange = 1'b0;
  logic ioLow = 1'b0;
  logic coreLow = 1'b0;
  logic [2:0] live = 3'b000;
  logic [12:3] flagIn = '0;
  logic pin;
  logic outN;
  logic outEn;
  logic [12:0] word;
  logic summaryError;
  logic [12:0] got;
  int fail_count = 0;
  int samples_checked = 0;
  logic [3:0] acc [4] = '{4'b1000, 4'b1010, 4'b0100, 4'b0101};
  always #10 clk = !clk;
  tsr_status_readout #(.IDLE_CYCLES(20)) dut (.clk(clk), .reset_n(reset_n), .mode_enable_pin(pin),
    .status_serial_out_n(outN), .statusOutEnable(outEn), .ioSupplyHigh(ioSupplyHigh),
    .ioSupplyLowRange(ioSupplyLowRange), .io_supply_low_flag(ioLow), .core_supply_low_flag(coreLow),
    .localWakeFlag(live[0]), .remoteWakeFlag(live[1]), .endpoint_config(live[2]), .power_on_seen(flagIn[3]),
    .busErrorFlag(flagIn[4]), .tempHighFlag(flagIn[5]), .tempMediumFlag(flagIn[6]), .tx_gate_stuck(flagIn[7]),
    .battery_low_status(flagIn[8]), .coreUndervoltFlag(flagIn[9]), .ioUndervoltFlag(flagIn[10]),
    .hub_lockout_entered(flagIn[11]), .branchCollision(flagIn[12]), .serial_status_word(word),
    .summaryError(summaryError));
  tsr_host_model host (.clk(clk), .statusOutEnable(outEn), .mode_enable_pin(pin));
  task automatic chk(string name, logic [12:0] e, logic [12:0] s);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, e, s);
    end
  endtask
  // read, then let the idle timeout run out
  task automatic rd(logic [12:0] e);
    host.read_word(got);
    repeat (60) @(negedge clk);
    chk("readout", e, got);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (5) @(negedge clk);
    live = 3'b101;
    repeat (10) @(negedge clk);
    chk("line", 13'h0001, {11'h000, outN, outEn});
    rd(13'h0005);
    live = 3'b010;
    flagIn = '1;
    repeat (10) @(negedge clk);
    flagIn = 10'h002;
    repeat (6) @(negedge clk);
    chk("word", 13'h1FFA, word);
    chk("summary", 13'h0001, {12'h000, summaryError});
    rd(13'h1FFA);
    rd(13'h001A);
    flagIn = '0;
    rd(13'h001A);
    rd(13'h000A);
    chk("summary", 13'h0000, {12'h000, summaryError});
    chk("line", 13'h0002, {11'h000, outN, outEn});
    foreach (acc[i]) begin
      {ioSupplyHigh, ioSupplyLowRange, ioLow, coreLow} = acc[i];
      repeat (10) @(negedge clk);
      rd(acc[i][1:0] == 2'b00 ? 13'h000A : 13'h0000);
    end
    complete_run();
  end
endmodule // tb
